// ===== core/mprt_core.v
// Multi-pipe address matching and autonomous transmit/receive sequencing.
`include "mprt_defs.vh"
`default_nettype none

module mprt_core #(
   parameter [`MPRT_CNT_W-1:0] SETTLE_CYC = `MPRT_SETTLE_CYC,
   parameter [`MPRT_CNT_W-1:0] ARD_STEP_CYC = `MPRT_ARD_STEP_CYC,
   parameter [`MPRT_CNT_W-1:0] ACK_WAIT_CYC = `MPRT_ACK_WAIT_CYC
) (
   input wire clk_sys,
   input wire arst_n,
   input wire radio_activate,
   input wire role_is_tx,
   input wire auto_ack_en,
   input wire crc_en,
   input wire [1:0] addr_width,
   input wire [`MPRT_NUM_PIPES-1:0] pipe_enable_bits,
   input wire [`MPRT_ADDR_W-1:0] pipe_zero_receive_address,
   input wire [`MPRT_SHARED_W-1:0] pipe_shared_address,
   input wire [`MPRT_LSB_W-1:0] pipe_1_address_lsb,
   input wire [`MPRT_LSB_W-1:0] pipe_2_address_lsb,
   input wire [`MPRT_LSB_W-1:0] pipe_3_address_lsb,
   input wire [`MPRT_LSB_W-1:0] pipe_4_address_lsb,
   input wire [`MPRT_LSB_W-1:0] pipe_5_address_lsb,
   input wire [3:0] retransmit_delay,
   input wire [3:0] retransmit_limit,
   input wire tx_fifo_not_empty,
   input wire tx_no_ack,
   input wire tx_pkt_done,
   input wire rx_addr_valid,
   input wire [`MPRT_ADDR_W-1:0] rx_addr,
   input wire rx_pkt_end,
   input wire rx_crc_ok,
   input wire rx_no_ack,
   output wire crc_check_on,
   output wire radio_tx_on,
   output wire radio_rx_on,
   output reg tx_pkt_start,
   output reg tx_is_ack,
   output reg [`MPRT_ADDR_W-1:0] ack_dest_addr,
   output reg tx_fifo_pop,
   output reg rx_payload_valid,
   output reg [`MPRT_PIPE_IDX_W-1:0] rx_pipe_number,
   output reg radio_interrupt,
   output reg irq_rx_ready,
   output reg irq_tx_done,
   output reg irq_max_retry
);

   localparam [9:0] S_IDLE = 10'h001;
   localparam [9:0] S_SETTLE = 10'h002;
   localparam [9:0] S_TX = 10'h004;
   localparam [9:0] S_ACKWAIT = 10'h008;
   localparam [9:0] S_ACKRECV = 10'h010;
   localparam [9:0] S_RETRY = 10'h020;
   localparam [9:0] S_RXSRCH = 10'h040;
   localparam [9:0] S_RXRECV = 10'h080;
   localparam [9:0] S_ACKSET = 10'h100;
   localparam [9:0] S_ACKTX = 10'h200;

   reg [9:0] state_reg;
   reg [`MPRT_CNT_W-1:0] cnt_reg;
   reg [`MPRT_CNT_W-1:0] ard_reg;
   reg [3:0] retry_reg;
   reg [`MPRT_PIPE_IDX_W-1:0] rx_pipe_reg;
   reg [`MPRT_NUM_PIPES-1:0] match;
   reg [`MPRT_PIPE_IDX_W-1:0] first_pipe;
   integer i;

   // Only the on-air address bytes take part in a compare.
   function [`MPRT_ADDR_W-1:0] width_mask;
      input [1:0] aw;
      begin
         case (aw)
            `MPRT_AW_3B: width_mask = 40'h00_00ff_ffff;
            `MPRT_AW_4B: width_mask = 40'h00_ffff_ffff;
            default: width_mask = 40'hff_ffff_ffff;
         endcase
      end
   endfunction

   function addr_eq;
      input [`MPRT_ADDR_W-1:0] a;
      input [`MPRT_ADDR_W-1:0] b;
      input [1:0] aw;
      begin
         addr_eq = ((a ^ b) & width_mask(aw)) == 40'h00_0000_0000;
      end
   endfunction

   // The product is kept in a wide variable so no bits are lost early.
   function [`MPRT_CNT_W-1:0] ard_load;
      input [3:0] d;
      input [`MPRT_CNT_W-1:0] step;
      reg [2*`MPRT_CNT_W-1:0] p;
      begin
         p = {24'h00_0000, {20'h0_0000, d} + 24'h00_0001} *
            {24'h00_0000, step};
         ard_load = p[`MPRT_CNT_W-1:0];
      end
   endfunction

   // Pipe 0 is a full address; pipes 1 to 5 reuse the shared upper bytes.
   wire [`MPRT_NUM_PIPES*`MPRT_ADDR_W-1:0] pipe_receive_address = {
      pipe_shared_address, pipe_5_address_lsb,
      pipe_shared_address, pipe_4_address_lsb,
      pipe_shared_address, pipe_3_address_lsb,
      pipe_shared_address, pipe_2_address_lsb,
      pipe_shared_address, pipe_1_address_lsb,
      pipe_zero_receive_address};

   // All pipes are decoded at once with one width setting.
   always @* begin
      match = 6'h00;
      first_pipe = 3'h0;
      for (i = `MPRT_NUM_PIPES - 1; i >= 0; i = i - 1) begin
         match[i] = pipe_enable_bits[i] &&
            addr_eq(rx_addr, pipe_receive_address[i*40 +: 40],
                    addr_width);
         if (match[i]) begin
            first_pipe = i[2:0];
         end
      end
   end

   // The transmitter takes its acknowledgement on its own pipe 0 address.
   wire ack_hit = rx_addr_valid &&
      addr_eq(rx_addr, pipe_zero_receive_address, addr_width);

   assign crc_check_on = crc_en | auto_ack_en;

   assign radio_tx_on = (state_reg == S_TX) || (state_reg == S_ACKTX);
   assign radio_rx_on = (state_reg == S_ACKWAIT) ||
      (state_reg == S_ACKRECV) || (state_reg == S_RXSRCH) ||
      (state_reg == S_RXRECV);

   // A missed or corrupt acknowledgement counts as one failed attempt.
   wire ack_fail =
      ((state_reg == S_ACKWAIT) && !ack_hit &&
       (cnt_reg <= 24'h00_0001)) ||
      ((state_reg == S_ACKRECV) && rx_pkt_end && !rx_crc_ok);

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= S_IDLE;
         cnt_reg <= 24'h00_0000;
         ard_reg <= 24'h00_0000;
         retry_reg <= 4'h0;
         rx_pipe_reg <= 3'h0;
         tx_pkt_start <= 1'b0;
         tx_is_ack <= 1'b0;
         ack_dest_addr <= 40'h00_0000_0000;
         tx_fifo_pop <= 1'b0;
         rx_payload_valid <= 1'b0;
         rx_pipe_number <= 3'h0;
         radio_interrupt <= 1'b0;
         irq_rx_ready <= 1'b0;
         irq_tx_done <= 1'b0;
         irq_max_retry <= 1'b0;
      end else begin
         tx_pkt_start <= 1'b0;
         tx_fifo_pop <= 1'b0;
         rx_payload_valid <= 1'b0;
         radio_interrupt <= 1'b0;
         irq_rx_ready <= 1'b0;
         irq_tx_done <= 1'b0;
         irq_max_retry <= 1'b0;
         if (ard_reg != 24'h00_0000) begin
            ard_reg <= ard_reg - 24'h00_0001;
         end
         case (state_reg)
            S_IDLE: begin
               retry_reg <= 4'h0;
               if (radio_activate) begin
                  if (role_is_tx) begin
                     if (tx_fifo_not_empty) begin
                        state_reg <= S_SETTLE;
                        cnt_reg <= SETTLE_CYC;
                     end
                  end else begin
                     state_reg <= S_RXSRCH;
                  end
               end
            end
            S_SETTLE: begin
               if (cnt_reg <= 24'h00_0001) begin
                  state_reg <= S_TX;
                  tx_pkt_start <= 1'b1;
                  tx_is_ack <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 24'h00_0001;
               end
            end
            S_TX: begin
               // The transmitter holds here for the packet's air time.
               if (tx_pkt_done) begin
                  ard_reg <= ard_load(retransmit_delay,
                                      ARD_STEP_CYC);
                  if (tx_no_ack || !auto_ack_en) begin
                     radio_interrupt <= 1'b1;
                     irq_tx_done <= 1'b1;
                     tx_fifo_pop <= 1'b1;
                     state_reg <= S_IDLE;
                  end else begin
                     state_reg <= S_ACKWAIT;
                     cnt_reg <= ACK_WAIT_CYC;
                  end
               end
            end
            S_ACKWAIT: begin
               if (ack_hit) begin
                  state_reg <= S_ACKRECV;
               end else begin
                  cnt_reg <= cnt_reg - 24'h00_0001;
               end
            end
            S_ACKRECV: begin
               if (rx_pkt_end && rx_crc_ok) begin
                  radio_interrupt <= 1'b1;
                  irq_tx_done <= 1'b1;
                  tx_fifo_pop <= 1'b1;
                  state_reg <= S_IDLE;
               end
            end
            S_RETRY: begin
               // Settling lies inside the retransmit delay window.
               // The start leaves at least one full delay after the end.
               if (ard_reg <= 24'h00_0001) begin
                  state_reg <= S_TX;
                  tx_pkt_start <= 1'b1;
                  tx_is_ack <= 1'b0;
               end
            end
            S_RXSRCH: begin
               if (!radio_activate) begin
                  state_reg <= S_IDLE;
               end else if (rx_addr_valid && (match != 6'h00)) begin
                  rx_pipe_reg <= first_pipe;
                  state_reg <= S_RXRECV;
               end
            end
            S_RXRECV: begin
               // Further address hits are ignored until this packet ends.
               if (rx_pkt_end) begin
                  if (rx_crc_ok || !crc_check_on) begin
                     rx_payload_valid <= 1'b1;
                     rx_pipe_number <= rx_pipe_reg;
                     radio_interrupt <= 1'b1;
                     irq_rx_ready <= 1'b1;
                     if (auto_ack_en && !rx_no_ack) begin
                        ack_dest_addr <=
                           pipe_receive_address[rx_pipe_reg*40 +: 40] &
                           width_mask(addr_width);
                        state_reg <= S_ACKSET;
                        cnt_reg <= SETTLE_CYC;
                     end else begin
                        state_reg <= S_RXSRCH;
                     end
                  end else begin
                     state_reg <= S_RXSRCH;
                  end
               end
            end
            S_ACKSET: begin
               if (cnt_reg <= 24'h00_0001) begin
                  state_reg <= S_ACKTX;
                  tx_pkt_start <= 1'b1;
                  tx_is_ack <= 1'b1;
               end else begin
                  cnt_reg <= cnt_reg - 24'h00_0001;
               end
            end
            S_ACKTX: begin
               if (tx_pkt_done) begin
                  state_reg <= S_RXSRCH;
               end
            end
            default: begin
               state_reg <= S_IDLE;
            end
         endcase
         // The packet stays queued after the last attempt fails.
         if (ack_fail) begin
            if (retry_reg == retransmit_limit) begin
               radio_interrupt <= 1'b1;
               irq_max_retry <= 1'b1;
               state_reg <= S_IDLE;
            end else begin
               retry_reg <= retry_reg + 4'h1;
               state_reg <= S_RETRY;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== core/mprt_defs.vh
// Shared constants for the multi-pipe receive and transaction sequencer.
`ifndef MPRT_DEFS_VH
`define MPRT_DEFS_VH

// System clock rate in MHz.
`define MPRT_CLK_MHZ 200

// Radio settling interval before a packet goes on air, in microseconds.
`define MPRT_SETTLE_US 130

// Retransmit delay step, in microseconds.
`define MPRT_ARD_STEP_US 250

// Longest wait for an acknowledgement address match, in microseconds.
`define MPRT_ACK_WAIT_US 250

// The same three intervals counted in cycles of the 200 MHz clock.
`define MPRT_SETTLE_CYC 24'h00_6590
`define MPRT_ARD_STEP_CYC 24'h00_c350
`define MPRT_ACK_WAIT_CYC 24'h00_c350

// Number of logical receive pipes and their index width.
`define MPRT_NUM_PIPES 6
`define MPRT_PIPE_IDX_W 3

// Pipe enable reset value: pipes 0 and 1 only.
`define MPRT_PIPE_EN_RST 6'h03

// Address field layout.
`define MPRT_ADDR_W 40
`define MPRT_SHARED_W 32
`define MPRT_LSB_W 8

// Shared address width encodings, in bytes on air.
`define MPRT_AW_3B 2'h1
`define MPRT_AW_4B 2'h2
`define MPRT_AW_5B 2'h3

// Timer width in bits; the timers count clock cycles.
`define MPRT_CNT_W 24

`endif

// ===== test/mprt_monitor.sv
// Port-level checker for the transaction sequencer, its interrupts and CRC forcing.
`include "mprt_defs.vh"
`default_nettype none
module mprt_monitor #(parameter int SETTLE_CYC = 20) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic crc_en,
   input wire logic auto_ack_en,
   input wire logic role_is_tx,
   input wire logic tx_no_ack,
   input wire logic tx_pkt_done,
   input wire logic rx_no_ack,
   input wire logic crc_check_on,
   input wire logic radio_tx_on,
   input wire logic radio_rx_on,
   input wire logic tx_pkt_start,
   input wire logic tx_is_ack,
   input wire logic tx_fifo_pop,
   input wire logic rx_payload_valid,
   input wire logic radio_interrupt,
   input wire logic irq_rx_ready,
   input wire logic irq_tx_done,
   input wire logic irq_max_retry
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int S = SETTLE_CYC;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_crc_forced:
      assert property (crc_check_on == (crc_en | auto_ack_en))
      else $error("crc check not forced");
   a_rx_irq:
      assert property (rx_payload_valid |-> radio_interrupt && irq_rx_ready)
      else $error("receive without interrupt");
   a_irq_cause:
      assert property (radio_interrupt |->
         irq_rx_ready || irq_tx_done || irq_max_retry)
      else $error("interrupt without cause");
   a_cause_irq:
      assert property (irq_rx_ready || irq_tx_done || irq_max_retry |->
         radio_interrupt) else $error("cause without interrupt");
   a_pop_ack:
      assert property (tx_fifo_pop |-> irq_tx_done && !irq_max_retry)
      else $error("pop without tx done");
   a_turn_rx:
      assert property (radio_tx_on && tx_pkt_done && auto_ack_en &&
         !tx_no_ack |=> radio_rx_on && !radio_tx_on)
      else $error("no turn to receive");
   a_noack_irq:
      assert property (role_is_tx && radio_tx_on && tx_pkt_done && tx_no_ack
         |=> irq_tx_done && tx_fifo_pop) else $error("no-ack not ended");
   a_rx_ack:
      assert property (rx_payload_valid && auto_ack_en && !$past(rx_no_ack)
         |-> ##[S:S] tx_pkt_start && tx_is_ack) else $error("ack late");
endmodule
bind mprt_core mprt_monitor #(.SETTLE_CYC(SETTLE_CYC)) mprt_monitor_i (
   .clk_sys(clk_sys), .arst_n(arst_n), .crc_en(crc_en),
   .auto_ack_en(auto_ack_en), .role_is_tx(role_is_tx),
   .tx_no_ack(tx_no_ack), .tx_pkt_done(tx_pkt_done), .rx_no_ack(rx_no_ack),
   .crc_check_on(crc_check_on), .radio_tx_on(radio_tx_on),
   .radio_rx_on(radio_rx_on), .tx_pkt_start(tx_pkt_start),
   .tx_is_ack(tx_is_ack), .tx_fifo_pop(tx_fifo_pop),
   .rx_payload_valid(rx_payload_valid), .radio_interrupt(radio_interrupt),
   .irq_rx_ready(irq_rx_ready), .irq_tx_done(irq_tx_done),
   .irq_max_retry(irq_max_retry));
`default_nettype wire

// ===== test/mprt_peer.sv
// Peer radio model: ends frames on air and sends frames in.
`default_nettype none
module mprt_peer #(parameter int AIR = 8) (
   input wire logic clk_sys,
   input wire logic tx_pkt_start,
   output logic tx_pkt_done,
   output logic rx_addr_valid,
   output logic [39:0] rx_addr,
   output logic rx_pkt_end,
   output logic rx_crc_ok,
   output logic rx_no_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {tx_pkt_done, rx_addr_valid, rx_addr, rx_pkt_end} = '0;
   initial {rx_crc_ok, rx_no_ack} = '0;
   always @(negedge clk_sys) begin
      tx_pkt_done = 1'b0;
      if (tx_pkt_start) begin
         repeat (AIR - 1) @(negedge clk_sys);
         tx_pkt_done = 1'b1;
      end
   end
   // Released lines show the inverse so a stale value can never match.
   task automatic send(input logic [39:0] a, input logic ok, nak);
      rx_addr_valid = 1'b1;
      rx_addr = a;
      @(negedge clk_sys);
      rx_addr_valid = 1'b0;
      rx_addr = ~a;
      repeat (AIR) @(negedge clk_sys);
      {rx_pkt_end, rx_crc_ok, rx_no_ack} = {1'b1, ok, nak};
      @(negedge clk_sys);
      {rx_pkt_end, rx_crc_ok, rx_no_ack} = {1'b0, ~ok, ~nak};
   endtask
endmodule
`default_nettype wire

// ===== test/testbench.sv
// Testbench for the pipe matcher and transaction sequencer.
`include "mprt_defs.vh"
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, arst_n, radio_activate, role_is_tx, auto_ack_en, crc_en;
   logic tx_fifo_not_empty, tx_no_ack, tx_pkt_done, rx_addr_valid;
   logic rx_pkt_end, rx_crc_ok, rx_no_ack, crc_check_on, radio_tx_on;
   logic radio_rx_on, tx_pkt_start, tx_is_ack, tx_fifo_pop;
   logic rx_payload_valid, radio_interrupt, irq_rx_ready, irq_tx_done;
   logic irq_max_retry;
   logic [1:0] addr_width;
   logic [5:0] pipe_enable_bits;
   logic [39:0] pipe_zero_receive_address, rx_addr, ack_dest_addr;
   logic [31:0] pipe_shared_address;
   logic [7:0] lsb [1:5];
   logic [3:0] retransmit_delay, retransmit_limit;
   logic [2:0] rx_pipe_number;
   int n_fail, checks_done, n_start;
   wire [3:0] ev;
   assign ev = {irq_max_retry, irq_tx_done, rx_payload_valid, tx_pkt_start};
   mprt_core #(.SETTLE_CYC(24'h14), .ARD_STEP_CYC(24'h28),
      .ACK_WAIT_CYC(24'h1e)) mprt_core_i (.clk_sys(clk_sys), .arst_n(arst_n),
      .radio_activate(radio_activate), .role_is_tx(role_is_tx),
      .auto_ack_en(auto_ack_en), .crc_en(crc_en), .addr_width(addr_width),
      .pipe_enable_bits(pipe_enable_bits),
      .pipe_zero_receive_address(pipe_zero_receive_address),
      .pipe_shared_address(pipe_shared_address),
      .pipe_1_address_lsb(lsb[1]), .pipe_2_address_lsb(lsb[2]),
      .pipe_3_address_lsb(lsb[3]), .pipe_4_address_lsb(lsb[4]),
      .pipe_5_address_lsb(lsb[5]), .retransmit_delay(retransmit_delay),
      .retransmit_limit(retransmit_limit),
      .tx_fifo_not_empty(tx_fifo_not_empty), .tx_no_ack(tx_no_ack),
      .tx_pkt_done(tx_pkt_done), .rx_addr_valid(rx_addr_valid),
      .rx_addr(rx_addr), .rx_pkt_end(rx_pkt_end), .rx_crc_ok(rx_crc_ok),
      .rx_no_ack(rx_no_ack), .crc_check_on(crc_check_on),
      .radio_tx_on(radio_tx_on), .radio_rx_on(radio_rx_on),
      .tx_pkt_start(tx_pkt_start), .tx_is_ack(tx_is_ack),
      .ack_dest_addr(ack_dest_addr), .tx_fifo_pop(tx_fifo_pop),
      .rx_payload_valid(rx_payload_valid), .rx_pipe_number(rx_pipe_number),
      .radio_interrupt(radio_interrupt), .irq_rx_ready(irq_rx_ready),
      .irq_tx_done(irq_tx_done), .irq_max_retry(irq_max_retry));
   mprt_peer mprt_peer_i (.clk_sys(clk_sys), .tx_pkt_start(tx_pkt_start),
      .tx_pkt_done(tx_pkt_done), .rx_addr_valid(rx_addr_valid),
      .rx_addr(rx_addr), .rx_pkt_end(rx_pkt_end), .rx_crc_ok(rx_crc_ok),
      .rx_no_ack(rx_no_ack));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(negedge clk_sys) if (tx_pkt_start) n_start++;
   function automatic logic [39:0] addr_of(input int p);
      if (p == 0) return pipe_zero_receive_address;
      return {pipe_shared_address, lsb[p]};
   endfunction
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input string what, input logic [39:0] e, g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   // Counts falling edges until the selected event shows, up to lim.
   task automatic await(input int s, lim, input bit hard, output int n);
      n = 0;
      while (ev[s] !== 1'b1 && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      if (hard && ev[s] !== 1'b1) begin
         n_fail++;
         $display("BAD wait %0d expected event seen none", s);
         tally_and_finish;
      end
   endtask
   // Activate stays up well past the minimum hold, with the queue emptied.
   task automatic tx_finish(input string name);
      tx_fifo_not_empty = 1'b0;
      repeat (2000) @(negedge clk_sys);
      radio_activate = 1'b0;
      repeat (2) @(negedge clk_sys);
      $display("done %s", name);
   endtask
   task automatic t_pipes;
      int n, q;
      auto_ack_en = 1'b1;
      radio_activate = 1'b1;
      @(negedge clk_sys);
      for (int p = 0; p < 9; p++) begin
         if (p == 3) pipe_enable_bits = 6'h3f;
         q = (p < 3) ? p : p - 3;
         mprt_peer_i.send(addr_of(q), 1'b1, 1'b0);
         await(1, 5, 0, n);
         chk("rx taken", (p == 2) ? 5 : 0, n);
         if (p != 2) chk("pipe", q, rx_pipe_number);
         if (p != 2) chk("ack dest", addr_of(q), ack_dest_addr);
         // Lets the acknowledgement finish before the next address arrives.
         repeat (40) @(negedge clk_sys);
      end
      crc_en = 1'b0;
      for (int a = 1; a >= 0; a--) begin
         auto_ack_en = a[0];
         mprt_peer_i.send(addr_of(0), 1'b0, 1'b1);
         await(1, 5, 0, n);
         chk("bad crc taken", a ? 5 : 0, n);
      end
      $display("done pipes");
   endtask
   task automatic t_ack;
      int n;
      {auto_ack_en, crc_en} = 2'h3;
      mprt_peer_i.send(addr_of(3), 1'b1, 1'b0);
      await(0, 40, 1, n);
      chk("ack settle", 20, n);
      chk("ack flag", 1, tx_is_ack);
      chk("ack tx on", 1, radio_tx_on);
      repeat (10) @(negedge clk_sys);
      chk("back to search", 1, radio_rx_on);
      tx_finish("ack");
   endtask
   task automatic t_tx(input logic nak);
      int n;
      {role_is_tx, tx_no_ack, tx_fifo_not_empty} = {1'b1, nak, 1'b1};
      radio_activate = 1'b1;
      await(0, 40, 1, n);
      chk("tx settle", 21, n);
      if (!nak) begin
         repeat (10) @(negedge clk_sys);
         chk("wait ack", 1, radio_rx_on);
         mprt_peer_i.send(addr_of(0), 1'b1, 1'b1);
      end
      await(2, 20, 1, n);
      chk("pop", 1, tx_fifo_pop);
      tx_finish("tx");
   endtask
   // The gap between starts is the air time plus the whole delay.
   task automatic t_retry(input logic [3:0] d);
      int n;
      {retransmit_limit, retransmit_delay} = {4'h1, d};
      {tx_no_ack, tx_fifo_not_empty} = 2'h1;
      n_start = 0;
      radio_activate = 1'b1;
      await(0, 40, 1, n);
      @(negedge clk_sys);
      await(0, 200, 1, n);
      chk("retry gap", 8 + (d + 1) * 40, n + 1);
      await(3, 100, 1, n);
      chk("starts", 2, n_start);
      tx_finish("retry");
   endtask
   initial begin
      {arst_n, radio_activate, role_is_tx, auto_ack_en, crc_en} = '0;
      {tx_fifo_not_empty, tx_no_ack, retransmit_delay, retransmit_limit} = '0;
      addr_width = `MPRT_AW_5B;
      pipe_enable_bits = `MPRT_PIPE_EN_RST;
      pipe_zero_receive_address = 40'hc3c3c3c3e7;
      pipe_shared_address = 32'hc2c2c2c2;
      for (int i = 1; i < 6; i++) lsb[i] = 8'hc0 + 8'(i);
      repeat (4) @(negedge clk_sys);
      arst_n = 1'b1;
      t_pipes;
      t_ack;
      t_tx(1'b1);
      t_tx(1'b0);
      t_retry(4'h0);
      t_retry(4'h1);
      tally_and_finish;
   end
endmodule
`default_nettype wire
